// File: canmbf_pkg.sv
// Package for the CAN message buffer formatter: word layout, sizes, types.
// Assumes a 16-bit word-addressed buffer RAM shared with the DMA engine.
package canmbf_pkg;

	// Buffer geometry
	localparam int BUF_WORDS = 8;
	localparam int NUM_BUFS = 32;
	localparam int BUF_IDX_W = 5;
	localparam int WORD_IDX_W = 3;
	localparam int ADDR_W = 16;
	localparam int WORD_W = 16;
	localparam int FIFO_DEPTH = 8;

	// Word indices inside one buffer
	localparam logic [2:0] W_IDENT = 3'h0;
	localparam logic [2:0] W_EXT_HIGH = 3'h1;
	localparam logic [2:0] W_EXT_LOW_LEN = 3'h2;
	localparam logic [2:0] W_DATA_0_1 = 3'h3;
	localparam logic [2:0] W_DATA_2_3 = 3'h4;
	localparam logic [2:0] W_DATA_4_5 = 3'h5;
	localparam logic [2:0] W_DATA_6_7 = 3'h6;
	localparam logic [2:0] W_FILTER_HIT = 3'h7;

	// Word 0 fields
	localparam int STD_ID_LSB = 2;
	localparam int STD_ID_MSB = 12;
	localparam int SRR_BIT = 1;
	localparam int IDE_BIT = 0;
	// Word 1 fields
	localparam int EXT_HI_LSB = 0;
	localparam int EXT_HI_MSB = 11;
	// Word 2 fields
	localparam int EXT_LO_LSB = 10;
	localparam int EXT_LO_MSB = 15;
	localparam int RTR_BIT = 9;
	localparam int RSV_HIGH_BIT = 8;
	localparam int RSV_LOW_BIT = 4;
	localparam int DLC_LSB = 0;
	localparam int DLC_MSB = 3;
	// Word 7 fields
	localparam int FHIT_LSB = 8;
	localparam int FHIT_MSB = 12;

	// Length code limit and reset values
	localparam logic [3:0] DLC_MAX = 4'h8;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;

	typedef struct packed {
		logic ide;
		logic srr;
		logic rtr;
		logic [10:0] standard_ident;
		logic [11:0] extended_ident_high;
		logic [5:0] extended_ident_low;
		logic [3:0] dlc;
		logic [63:0] data;
	} canmbf_frame_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
	} canmbf_ram_wr_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'h0,
		RX_WRITE = 2'h1,
		RX_DRAIN = 2'h3
	} canmbf_rx_state_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_READ = 2'h1,
		TX_LAST = 2'h3,
		TX_HOLD = 2'h2
	} canmbf_tx_state_t;

endpackage : canmbf_pkg

// File: canmbf_fifo.sv
// Small synchronous FIFO built from flip-flops, valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
module canmbf_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// Status
	output logic empty
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != (PW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign empty = (count_reg == '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_ptr_reg];

	always_ff @(posedge mclk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule : canmbf_fifo

// File: canmbf_core.sv
// CAN message buffer formatter: packs received frames into eight-word RAM
// buffers and unpacks transmit buffers read back from the same RAM.
// Assumes a word-addressed RAM with one-cycle read latency and a write port
// that may stall; buffer modes and the area come from control logic outside.
`timescale 1ns/1ps
module canmbf_core (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Buffer area set by software
	input wire logic [canmbf_pkg::ADDR_W-1:0] area_base,
	input wire logic [5:0] area_bufs,
	input wire logic [canmbf_pkg::NUM_BUFS-1:0] buf_is_tx,
	// Received frame from the protocol engine
	input wire logic rx_valid,
	output logic rx_ready,
	input wire canmbf_pkg::canmbf_frame_t rx_frame,
	input wire logic [4:0] rx_filter,
	input wire logic [canmbf_pkg::BUF_IDX_W-1:0] rx_buf,
	output logic rx_reject,
	// Flags
	input wire logic [canmbf_pkg::NUM_BUFS-1:0] full_clr,
	input wire logic [canmbf_pkg::NUM_BUFS-1:0] overrun_clr,
	output logic [canmbf_pkg::NUM_BUFS-1:0] receive_full_flag,
	output logic [canmbf_pkg::NUM_BUFS-1:0] receive_overrun_flag,
	// RAM write port
	output logic ram_wr_valid,
	input wire logic ram_wr_ready,
	output logic [canmbf_pkg::ADDR_W-1:0] ram_wr_addr,
	output logic [canmbf_pkg::WORD_W-1:0] ram_wr_data,
	// RAM read port
	output logic ram_rd_en,
	output logic [canmbf_pkg::ADDR_W-1:0] ram_rd_addr,
	input wire logic [canmbf_pkg::WORD_W-1:0] ram_rd_data,
	// Transmit request and decoded frame
	input wire logic tx_req,
	input wire logic [canmbf_pkg::BUF_IDX_W-1:0] tx_buf,
	output logic tx_busy,
	output logic tx_frame_valid,
	input wire logic tx_frame_ready,
	output canmbf_pkg::canmbf_frame_t tx_frame,
	output logic tx_remote
);

	// Address of one word inside the area
	function automatic logic [canmbf_pkg::ADDR_W-1:0] word_addr(
		input logic [canmbf_pkg::ADDR_W-1:0] base,
		input logic [canmbf_pkg::BUF_IDX_W-1:0] idx,
		input logic [2:0] word
	);
		logic [canmbf_pkg::ADDR_W-1:0] off;
		off = {{(canmbf_pkg::ADDR_W-8){1'b0}}, idx, word};
		return base + off;
	endfunction : word_addr

	// Build one buffer word from a received frame
	function automatic logic [15:0] pack_word(
		input canmbf_pkg::canmbf_frame_t f,
		input logic [4:0] fhit,
		input logic [2:0] word
	);
		logic [15:0] w;
		logic [3:0] len;
		logic [63:0] dat;
		w = canmbf_pkg::WORD_ZERO;
		len = (f.dlc > canmbf_pkg::DLC_MAX) ? canmbf_pkg::DLC_MAX : f.dlc;
		// Bytes past the length go out as zero, not stale data
		for (int b = 0; b < 8; b++) begin
			dat[b*8 +: 8] = (4'(b) < len) ? f.data[b*8 +: 8] : 8'h00;
		end
		case (word)
			canmbf_pkg::W_IDENT: begin
				w[canmbf_pkg::STD_ID_MSB:canmbf_pkg::STD_ID_LSB] =
					f.standard_ident;
				w[canmbf_pkg::SRR_BIT] = f.srr;
				w[canmbf_pkg::IDE_BIT] = f.ide;
			end
			canmbf_pkg::W_EXT_HIGH: begin
				w[canmbf_pkg::EXT_HI_MSB:canmbf_pkg::EXT_HI_LSB] =
					f.extended_ident_high;
			end
			canmbf_pkg::W_EXT_LOW_LEN: begin
				w[canmbf_pkg::EXT_LO_MSB:canmbf_pkg::EXT_LO_LSB] =
					f.extended_ident_low;
				w[canmbf_pkg::RTR_BIT] = f.rtr;
				w[canmbf_pkg::DLC_MSB:canmbf_pkg::DLC_LSB] = f.dlc;
			end
			canmbf_pkg::W_DATA_0_1: begin
				w = dat[15:0];
			end
			canmbf_pkg::W_DATA_2_3: begin
				w = dat[31:16];
			end
			canmbf_pkg::W_DATA_4_5: begin
				w = dat[47:32];
			end
			canmbf_pkg::W_DATA_6_7: begin
				w = dat[63:48];
			end
			canmbf_pkg::W_FILTER_HIT: begin
				w[canmbf_pkg::FHIT_MSB:canmbf_pkg::FHIT_LSB] = fhit;
			end
			default: begin
				w = canmbf_pkg::WORD_ZERO;
			end
		endcase
		return w;
	endfunction : pack_word

	// Receive path state
	canmbf_pkg::canmbf_rx_state_t rx_state_reg;
	canmbf_pkg::canmbf_frame_t rx_frame_reg;
	logic [4:0] rx_filter_reg;
	logic [canmbf_pkg::BUF_IDX_W-1:0] rx_buf_reg;
	logic [2:0] rx_word_reg;
	logic rx_accept;
	logic rx_in_area;
	logic rx_target_tx;
	logic rx_target_full;
	logic set_full;
	logic set_overrun;
	logic reject_reg;

	// FIFO fill and drain sides
	canmbf_pkg::canmbf_ram_wr_t fifo_in;
	canmbf_pkg::canmbf_ram_wr_t fifo_out;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_empty;

	assign rx_ready = (rx_state_reg == canmbf_pkg::RX_IDLE);
	assign rx_accept = rx_valid && rx_ready;
	assign rx_in_area = ({1'b0, rx_buf} < area_bufs);
	assign rx_target_tx = buf_is_tx[rx_buf];
	assign rx_target_full = receive_full_flag[rx_buf];
	assign rx_reject = reject_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_reg <= canmbf_pkg::RX_IDLE;
			rx_word_reg <= '0;
			reject_reg <= 1'b0;
		end else begin
			reject_reg <= 1'b0;
			case (rx_state_reg)
				canmbf_pkg::RX_IDLE: begin
					rx_word_reg <= '0;
					if (rx_accept) begin
						// Transmit buffers and full buffers keep their contents
						if (!rx_in_area || rx_target_tx || rx_target_full) begin
							reject_reg <= 1'b1;
						end else begin
							rx_state_reg <= canmbf_pkg::RX_WRITE;
						end
					end
				end
				canmbf_pkg::RX_WRITE: begin
					if (fifo_in_ready) begin
						rx_word_reg <= rx_word_reg + 3'h1;
						if (rx_word_reg == canmbf_pkg::W_FILTER_HIT) begin
							rx_state_reg <= canmbf_pkg::RX_DRAIN;
						end
					end
				end
				canmbf_pkg::RX_DRAIN: begin
					// Flag only once every word has reached RAM
					if (fifo_empty) begin
						rx_state_reg <= canmbf_pkg::RX_IDLE;
					end
				end
				default: begin
					rx_state_reg <= canmbf_pkg::RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_frame_reg <= '0;
			rx_filter_reg <= '0;
			rx_buf_reg <= '0;
		end else if (rx_accept) begin
			rx_frame_reg <= rx_frame;
			rx_filter_reg <= rx_filter;
			rx_buf_reg <= rx_buf;
		end
	end

	assign fifo_in_valid = (rx_state_reg == canmbf_pkg::RX_WRITE);
	assign fifo_in.addr = word_addr(area_base, rx_buf_reg, rx_word_reg);
	assign fifo_in.data = pack_word(rx_frame_reg, rx_filter_reg, rx_word_reg);

	canmbf_fifo #(
		.WIDTH($bits(canmbf_pkg::canmbf_ram_wr_t)),
		.DEPTH(canmbf_pkg::FIFO_DEPTH)
	) u_wr_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(ram_wr_valid),
		.out_ready(ram_wr_ready),
		.out_data(fifo_out),
		.empty(fifo_empty)
	);

	assign ram_wr_addr = fifo_out.addr;
	assign ram_wr_data = fifo_out.data;

	// Flag set wins over a clear in the same cycle
	always_comb begin
		set_full = (rx_state_reg == canmbf_pkg::RX_DRAIN) && fifo_empty;
		set_overrun = rx_accept && rx_in_area && !rx_target_tx &&
			rx_target_full;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			receive_full_flag <= canmbf_pkg::FLAGS_RESET;
		end else begin
			for (int i = 0; i < canmbf_pkg::NUM_BUFS; i++) begin
				if (set_full && (rx_buf_reg == canmbf_pkg::BUF_IDX_W'(i))) begin
					receive_full_flag[i] <= 1'b1;
				end else if (full_clr[i]) begin
					receive_full_flag[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			receive_overrun_flag <= canmbf_pkg::FLAGS_RESET;
		end else begin
			for (int i = 0; i < canmbf_pkg::NUM_BUFS; i++) begin
				if (set_overrun && (rx_buf == canmbf_pkg::BUF_IDX_W'(i))) begin
					receive_overrun_flag[i] <= 1'b1;
				end else if (overrun_clr[i]) begin
					receive_overrun_flag[i] <= 1'b0;
				end
			end
		end
	end

	// Transmit path: read eight words, one-cycle RAM latency
	canmbf_pkg::canmbf_tx_state_t tx_state_reg;
	logic [canmbf_pkg::BUF_IDX_W-1:0] tx_buf_reg;
	logic [2:0] rd_word_reg;
	logic cap_valid_reg;
	logic [2:0] cap_word_reg;
	logic [15:0] tx_words_reg [canmbf_pkg::BUF_WORDS];
	logic tx_start;

	assign tx_busy = (tx_state_reg != canmbf_pkg::TX_IDLE);
	assign tx_start = tx_req && !tx_busy && ({1'b0, tx_buf} < area_bufs);
	assign ram_rd_en = (tx_state_reg == canmbf_pkg::TX_READ);
	assign ram_rd_addr = word_addr(area_base, tx_buf_reg, rd_word_reg);
	assign tx_frame_valid = (tx_state_reg == canmbf_pkg::TX_HOLD);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_reg <= canmbf_pkg::TX_IDLE;
			tx_buf_reg <= '0;
			rd_word_reg <= '0;
		end else begin
			case (tx_state_reg)
				canmbf_pkg::TX_IDLE: begin
					rd_word_reg <= '0;
					if (tx_start) begin
						tx_buf_reg <= tx_buf;
						tx_state_reg <= canmbf_pkg::TX_READ;
					end
				end
				canmbf_pkg::TX_READ: begin
					rd_word_reg <= rd_word_reg + 3'h1;
					if (rd_word_reg == canmbf_pkg::W_FILTER_HIT) begin
						tx_state_reg <= canmbf_pkg::TX_LAST;
					end
				end
				canmbf_pkg::TX_LAST: begin
					tx_state_reg <= canmbf_pkg::TX_HOLD;
				end
				canmbf_pkg::TX_HOLD: begin
					if (tx_frame_ready) begin
						tx_state_reg <= canmbf_pkg::TX_IDLE;
					end
				end
				default: begin
					tx_state_reg <= canmbf_pkg::TX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cap_valid_reg <= 1'b0;
			cap_word_reg <= '0;
		end else begin
			cap_valid_reg <= ram_rd_en;
			cap_word_reg <= rd_word_reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < canmbf_pkg::BUF_WORDS; i++) begin
				tx_words_reg[i] <= canmbf_pkg::WORD_ZERO;
			end
		end else if (cap_valid_reg) begin
			tx_words_reg[cap_word_reg] <= ram_rd_data;
		end
	end

	// Decode the captured words; word 7 is never written back
	always_comb begin
		logic [15:0] w0;
		logic [15:0] w2;
		logic [3:0] len;
		logic [63:0] raw;
		w0 = tx_words_reg[canmbf_pkg::W_IDENT];
		w2 = tx_words_reg[canmbf_pkg::W_EXT_LOW_LEN];
		raw = {tx_words_reg[canmbf_pkg::W_DATA_6_7],
			tx_words_reg[canmbf_pkg::W_DATA_4_5],
			tx_words_reg[canmbf_pkg::W_DATA_2_3],
			tx_words_reg[canmbf_pkg::W_DATA_0_1]};
		len = w2[canmbf_pkg::DLC_MSB:canmbf_pkg::DLC_LSB];
		if (len > canmbf_pkg::DLC_MAX) begin
			len = canmbf_pkg::DLC_MAX;
		end
		tx_frame = '0;
		tx_frame.standard_ident =
			w0[canmbf_pkg::STD_ID_MSB:canmbf_pkg::STD_ID_LSB];
		tx_frame.srr = w0[canmbf_pkg::SRR_BIT];
		tx_frame.ide = w0[canmbf_pkg::IDE_BIT];
		tx_frame.extended_ident_high = tx_words_reg[canmbf_pkg::W_EXT_HIGH]
			[canmbf_pkg::EXT_HI_MSB:canmbf_pkg::EXT_HI_LSB];
		tx_frame.extended_ident_low =
			w2[canmbf_pkg::EXT_LO_MSB:canmbf_pkg::EXT_LO_LSB];
		tx_frame.rtr = w2[canmbf_pkg::RTR_BIT];
		tx_frame.dlc = w2[canmbf_pkg::DLC_MSB:canmbf_pkg::DLC_LSB];
		for (int b = 0; b < 8; b++) begin
			tx_frame.data[b*8 +: 8] =
				(4'(b) < len) ? raw[b*8 +: 8] : 8'h00;
		end
		// Standard frames ask for remote data through SRR, not RTR
		tx_remote = tx_frame.ide ? tx_frame.rtr : tx_frame.srr;
	end

endmodule : canmbf_core

// File: canmbf_checker.sv
// Checker for the message buffer formatter, watching the core's ports.
// Assumes the buffer area base is aligned to eight words.
`timescale 1ns/1ps
module canmbf_checker (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Area and receive side
	input wire logic [15:0] area_base,
	input wire logic [5:0] area_bufs,
	input wire logic [31:0] buf_is_tx,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic [4:0] rx_buf,
	input wire logic rx_reject,
	input wire logic [31:0] receive_full_flag,
	// RAM ports
	input wire logic ram_wr_valid,
	input wire logic [15:0] ram_wr_addr,
	input wire logic [15:0] ram_wr_data,
	input wire logic ram_rd_en,
	input wire logic [15:0] ram_rd_addr,
	// Transmit side
	input wire logic tx_req,
	input wire logic [4:0] tx_buf,
	input wire logic tx_busy,
	input wire logic tx_frame_valid,
	input wire canmbf_pkg::canmbf_frame_t tx_frame,
	input wire logic tx_remote
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic acc;
	logic bad;
	logic [2:0] wofs;
	logic [2:0] rofs;
	assign acc = rx_valid && rx_ready;
	assign bad = {1'b0, rx_buf} >= area_bufs || buf_is_tx[rx_buf];
	assign wofs = ram_wr_addr[2:0] - area_base[2:0];
	assign rofs = ram_rd_addr[2:0] - area_base[2:0];

	a_refuse_full: assert property (
		acc && receive_full_flag[rx_buf] |=> rx_reject)
		else $error("full buffer store not refused");
	a_refuse_tx_buf: assert property (
		acc && buf_is_tx[rx_buf] |=> rx_reject)
		else $error("store into transmit buffer not refused");
	a_refuse_range: assert property (
		acc && {1'b0, rx_buf} >= area_bufs |=> rx_reject)
		else $error("store outside area not refused");
	a_accept_store: assert property (
		acc && !bad && !receive_full_flag[rx_buf] |=> !rx_ready && !rx_reject)
		else $error("good frame not taken");
	a_write_in_area: assert property (
		ram_wr_valid |-> ram_wr_addr >= area_base &&
		ram_wr_addr < area_base + 16'({area_bufs, 3'h0}))
		else $error("write outside buffer area");
	a_word0_pad: assert property (
		ram_wr_valid && wofs == 3'h0 |-> ram_wr_data[15:13] == 3'h0)
		else $error("word 0 top bits not zero");
	a_word1_pad: assert property (
		ram_wr_valid && wofs == 3'h1 |-> ram_wr_data[15:12] == 4'h0)
		else $error("word 1 top bits not zero");
	a_word2_rsv: assert property (
		ram_wr_valid && wofs == 3'h2 |-> ram_wr_data[8:4] == 5'h00)
		else $error("word 2 reserved bits not zero");
	a_word7_pad: assert property (
		ram_wr_valid && wofs == 3'h7 |->
		ram_wr_data[15:13] == 3'h0 && ram_wr_data[7:0] == 8'h00)
		else $error("word 7 spare bits not zero");
	a_read_order: assert property (
		ram_rd_en && rofs != 3'h7 |=>
		ram_rd_en && ram_rd_addr == $past(ram_rd_addr) + 16'h1)
		else $error("buffer words not read in order");
	a_tx_answer: assert property (
		tx_req && !tx_busy && {1'b0, tx_buf} < area_bufs |-> ##10 tx_frame_valid)
		else $error("decoded frame late");
	a_remote_select: assert property (
		tx_frame_valid |->
		tx_remote == (tx_frame.ide ? tx_frame.rtr : tx_frame.srr))
		else $error("remote flag wrongly selected");
endmodule : canmbf_checker

bind canmbf_core canmbf_checker u_canmbf_checker (
	.mclk(mclk), .rst_n(rst_n), .area_base(area_base),
	.area_bufs(area_bufs), .buf_is_tx(buf_is_tx), .rx_valid(rx_valid),
	.rx_ready(rx_ready), .rx_buf(rx_buf), .rx_reject(rx_reject),
	.receive_full_flag(receive_full_flag), .ram_wr_valid(ram_wr_valid),
	.ram_wr_addr(ram_wr_addr), .ram_wr_data(ram_wr_data),
	.ram_rd_en(ram_rd_en), .ram_rd_addr(ram_rd_addr), .tx_req(tx_req),
	.tx_buf(tx_buf), .tx_busy(tx_busy), .tx_frame_valid(tx_frame_valid),
	.tx_frame(tx_frame), .tx_remote(tx_remote)
);

// File: canmbf_ram_model.sv
// Model of the DMA-reachable RAM holding the message buffers.
// Assumes the core's write handshake and one-cycle read latency.
`timescale 1ns/1ps
module canmbf_ram_model (
	// Clock
	input wire logic mclk,
	// Write port
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [15:0] wr_addr,
	input wire logic [15:0] wr_data,
	// Read port
	input wire logic rd_en,
	input wire logic [15:0] rd_addr,
	output logic [15:0] rd_data,
	// Slow memory when high
	input wire logic stall
);
	logic [15:0] mem [0:255];
	logic tick = 1'b0;
	initial rd_data = 16'h5A5A;
	assign wr_ready = !stall || tick;
	always @(posedge mclk) begin
		tick <= ~tick;
		if (wr_valid && wr_ready) begin
			mem[wr_addr[7:0]] <= wr_data;
		end
		// Read data only lasts one cycle; a stale value must not pass
		rd_data <= rd_en ? mem[rd_addr[7:0]] : ~rd_data;
	end
endmodule : canmbf_ram_model

// File: canmbf_core_tb.sv
// Self-checking bench for the message buffer formatter core.
// Assumes the RAM model and checker files are compiled alongside.
`timescale 1ns/1ps
module canmbf_core_tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic rx_valid = 1'b0, rx_ready, rx_reject, tx_req = 1'b0, tx_busy;
	logic tx_frame_valid, tx_frame_ready = 1'b0, tx_remote, stall = 1'b0;
	logic [4:0] rx_filter = 5'h00, rx_buf = 5'h00, tx_buf = 5'h00;
	logic [31:0] full_clr = 32'h0, overrun_clr = 32'h0, full_f, ovr_f;
	logic wr_valid, wr_ready, rd_en;
	logic [15:0] wr_addr, wr_data, rd_addr, rd_data;
	canmbf_pkg::canmbf_frame_t rx_frame = '0;
	canmbf_pkg::canmbf_frame_t tx_frame;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	always #10 mclk = ~mclk;

	canmbf_core u_canmbf_core (.mclk(mclk), .rst_n(rst_n),
		.area_base(16'h0040), .area_bufs(6'h04), .buf_is_tx(32'h8),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_frame(rx_frame),
		.rx_filter(rx_filter), .rx_buf(rx_buf), .rx_reject(rx_reject),
		.full_clr(full_clr), .overrun_clr(overrun_clr),
		.receive_full_flag(full_f), .receive_overrun_flag(ovr_f),
		.ram_wr_valid(wr_valid), .ram_wr_ready(wr_ready),
		.ram_wr_addr(wr_addr), .ram_wr_data(wr_data), .ram_rd_en(rd_en),
		.ram_rd_addr(rd_addr), .ram_rd_data(rd_data), .tx_req(tx_req),
		.tx_buf(tx_buf), .tx_busy(tx_busy), .tx_frame_valid(tx_frame_valid),
		.tx_frame_ready(tx_frame_ready), .tx_frame(tx_frame),
		.tx_remote(tx_remote));
	canmbf_ram_model u_canmbf_ram_model (.mclk(mclk), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .stall(stall));

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	task automatic rx_send(input logic [4:0] b, input logic rej);
		int n;
		logic was_full;
		rx_valid <= 1'b1;
		rx_buf <= b;
		do @(posedge mclk); while (!rx_ready);
		rx_valid <= 1'b0;
		// Reject pulse lasts one cycle, so look just after the take edge
		#1;
		was_full = full_f[b];
		check(rx_reject, rej);
		for (n = 0; n < 80 && !rej && !full_f[b]; n++) @(posedge mclk);
		check(full_f[b], was_full || !rej);
		@(posedge mclk);
	endtask : rx_send

	task automatic test_rx_store;
		logic [15:0] e [0:7];
		e = '{{3'h0, 11'h5A5, 2'b11}, 16'h0ABC, {6'h2D, 2'b10, 8'h03},
			16'h2211, 16'h0033, 16'h0000, 16'h0000, 16'h1300};
		stall <= 1'b1;
		rx_filter <= 5'h13;
		rx_frame <= '{ide: 1'b1, srr: 1'b1, rtr: 1'b1, standard_ident: 11'h5A5,
			extended_ident_high: 12'hABC, extended_ident_low: 6'h2D,
			dlc: 4'h3, data: 64'h8877665544332211};
		rx_send(5'h02, 1'b0);
		stall <= 1'b0;
		for (int k = 0; k < 8; k++)
			check(u_canmbf_ram_model.mem[80 + k], e[k]);
		$display("test rx_store done");
	endtask : test_rx_store

	task automatic test_rx_refuse;
		u_canmbf_ram_model.mem[95] = 16'hBEEF;
		rx_send(5'h02, 1'b1);
		check(ovr_f[2], 1'b1);
		check(u_canmbf_ram_model.mem[87], 16'h1300);
		rx_send(5'h03, 1'b1);
		check(u_canmbf_ram_model.mem[95], 16'hBEEF);
		rx_send(5'h05, 1'b1);
		full_clr <= 32'h4;
		overrun_clr <= 32'h4;
		@(posedge mclk);
		full_clr <= 32'h0;
		overrun_clr <= 32'h0;
		@(posedge mclk);
		#1;
		check({full_f[2], ovr_f[2]}, 2'b00);
		@(posedge mclk);
		$display("test rx_refuse done");
	endtask : test_rx_refuse

	task automatic tx_run(input logic [4:0] b, input logic [15:0] w0,
		input logic [15:0] w2, input logic [63:0] dat, input logic rem);
		int n;
		logic [15:0] w [0:7];
		w = '{w0, 16'h0ABC, w2, 16'h2211, 16'h4433, 16'h6655, 16'h8877,
			16'h1F00};
		for (n = 0; n < 8; n++) u_canmbf_ram_model.mem[64 + b * 8 + n] = w[n];
		tx_req <= 1'b1;
		tx_buf <= b;
		@(posedge mclk);
		tx_req <= 1'b0;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			#1;
		end while (!tx_frame_valid && n < 20);
		// Seen 1 ns after edge 9, so sampled high at edge 10
		check(n, 9);
		check(tx_frame.standard_ident, w0[12:2]);
		check({tx_frame.extended_ident_high, tx_frame.extended_ident_low},
			{12'hABC, w2[15:10]});
		check(tx_frame.dlc, w2[3:0]);
		check(tx_frame.data, dat);
		check(tx_remote, rem);
		check(tx_busy, 1'b1);
		@(posedge mclk);
		tx_frame_ready <= 1'b1;
		@(posedge mclk);
		tx_frame_ready <= 1'b0;
		@(posedge mclk);
		check(tx_busy, 1'b0);
		check(u_canmbf_ram_model.mem[64 + b * 8 + 7], 16'h1F00);
	endtask : tx_run

	task automatic test_tx_decode;
		tx_run(5'h01, {3'h0, 11'h123, 2'b00}, {6'h15, 2'b10, 8'h02},
			64'h2211, 1'b0);
		tx_run(5'h03, {3'h0, 11'h123, 2'b11}, {6'h15, 2'b10, 8'h08},
			64'h8877665544332211, 1'b1);
		$display("test tx_decode done");
	endtask : test_tx_decode

	// Whole run needs well under a thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			$display("mismatch at %0t: run did not finish", $time);
			give_verdict();
		end
	end

	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		test_rx_store();
		test_rx_refuse();
		test_tx_decode();
		give_verdict();
	end
endmodule : canmbf_core_tb
